//--- dv/dsp_ctrl_model.sv
// Model of the external controller on the status port pins
`timescale 1ns/10ps
module dsp_ctrl_model (
	// Clock
	input wire logic core_clk,
	// Commands from the bench
	input wire logic readReq,
	input wire logic strapDrive,
	input wire logic [19:0] strapVal,
	// Pins
	output logic port_select_n,
	output logic port_read_qualifier,
	output logic [19:0] extPins
);
	initial
	begin
		port_select_n = 1'b1;
		port_read_qualifier = 1'b0;
		extPins = 20'h00000;
	end
	always @(posedge core_clk)
	begin
		port_select_n <= #1 ~readReq;
		port_read_qualifier <= #1 readReq;
		// Released lines have no pull, so they wander every cycle
		extPins <= #1 strapDrive ? strapVal : ~extPins;
	end
endmodule

//--- dv/testbench.sv
// Self-checking bench for the decoder status parallel port
`timescale 1ns/10ps
module testbench;
	import dsp_pkg::*;
	localparam logic [19:0] CHK = 20'hE311F;
	logic core_clk = 1'b0, srst = 1'b1, porN = 1'b1, convEn = 1'b0;
	logic decEn = 1'b1, refSeen = 1'b0, locked = 1'b0, needData = 1'b0;
	logic hdrValid = 1'b0, frameFail = 1'b0, frameStart = 1'b0;
	logic ancRead = 1'b0, altEn = 1'b0, readReq = 1'b0, strapDrive = 1'b1;
	logic syncExp = 1'b0, crcExp = 1'b0, pSel, pRd, coreRun, ready;
	logic [31:0] hdrWord = 32'h00000000, lastW = 32'h00000000;
	logic [19:0] strapVal = 20'h00000, extPins, pioIn, pioOut, pioOe;
	logic [2:0] alt, dma;
	logic [3:0] rdy [4] = '{4'h5, 4'h2, 4'hC, 4'hB};
	logic [19:0] bootVal [2] = '{20'h00015, 20'h0010A};
	logic [5:0] bootExp [2] = '{6'h15, 6'h2A};
	dsp_straps_t straps;
	int fails = 0, compares = 0, cycles = 0;
	always #2 core_clk = ~core_clk;
	assign pioIn = (pioOe & pioOut) | (~pioOe & extPins);
	dsp_ctrl_model dsp_ctrl_model_inst (.core_clk(core_clk),
		.readReq(readReq), .strapDrive(strapDrive), .strapVal(strapVal),
		.port_select_n(pSel), .port_read_qualifier(pRd), .extPins(extPins));
	dsp_status_port #(.SETTLE_CYC(2)) dsp_status_port_inst (
		.core_clk(core_clk), .srst(srst), .power_on_reset_n(porN),
		.converter_enable_in(convEn), .decoder_enable_in(decEn),
		.port_select_n(pSel), .port_read_qualifier(pRd), .pioIn(pioIn),
		.pioOut(pioOut), .pioOe(pioOe), .refClockSeen(refSeen),
		.synthLocked(locked), .needData(needData), .hdrValid(hdrValid),
		.hdrWord(hdrWord), .frameFail(frameFail), .frameStart(frameStart),
		.ancRead(ancRead), .altSerialEn(altEn),
		.alt_serial_in_clock(alt[2]), .alt_serial_in_frame(alt[1]),
		.alt_serial_in_data(alt[0]), .straps(straps), .coreRun(coreRun),
		.decoder_ready_out(ready), .dma_ready_read(dma[2]),
		.dma_ready_write(dma[1]), .dma_end_flag(dma[0]));
	task automatic results();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string name, input logic [19:0] exp,
		input logic [19:0] got);
		compares++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic pins();
		chk("pins", {needData, lastW[11], lastW[12], 3'h0, lastW[13],
			lastW[14], 3'h0, crcExp, 3'h0, syncExp, lastW[20], lastW[21],
			lastW[30], lastW[31]}, pioOut & CHK);
	endtask
	// Decoder events: {frameFail, frameStart, ancRead}
	task automatic ev(input logic [2:0] w);
		{frameFail, frameStart, ancRead} = w;
		tick(1);
		{frameFail, frameStart, ancRead} = 3'h0;
		tick(3);
	endtask
	task automatic hdr(input logic [31:0] w);
		hdrWord = w;
		hdrValid = 1'b1;
		lastW = w;
		syncExp = syncExp | (w[13] ^ w[14]);
		tick(1);
		hdrValid = 1'b0;
		tick(3);
	endtask
	// Straps are only taken while the partner still drives them
	task automatic boot(input logic [19:0] s);
		srst = 1'b1;
		convEn = 1'b0;
		strapDrive = 1'b1;
		strapVal = s;
		tick(4);
		chk("oe in reset", 20'h0, pioOe);
		chk("straps in reset", 20'h0, {14'h0, straps});
		srst = 1'b0;
		convEn = 1'b1;
		for (int i = 0; i < 200 && coreRun !== 1'b1; i++)
			tick(1);
		chk("run", 20'h1, {19'h0, coreRun});
		strapDrive = 1'b0;
	endtask
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			fails++;
			results();
		end
	end
	initial
	begin
		readReq = 1'b1;
		for (int i = 0; i < 2; i++)
		begin
			boot(bootVal[i]);
			chk("straps", bootExp[i], {14'h0, straps});
		end
		tick(20);
		chk("straps held", 20'h2A, {14'h0, straps});
		chk("oe", CHK, pioOe);
		chk("dma", 20'h0, {17'h0, dma});
		pins();
		hdr(32'h80003800);
		pins();
		hdrWord = 32'h7FFFC7FF;
		tick(3);
		pins();
		ev(3'h1);
		syncExp = 1'b0;
		pins();
		hdr(32'h40006000);
		pins();
		hdr(32'h00104800);
		pins();
		ev(3'h4);
		pins();
		ev(3'h2);
		crcExp = 1'b1;
		pins();
		ev(3'h2);
		crcExp = 1'b0;
		pins();
		needData = 1'b1;
		tick(3);
		pins();
		readReq = 1'b0;
		tick(5);
		chk("oe idle", 20'h0, pioOe);
		strapDrive = 1'b1;
		strapVal = 20'h14000;
		altEn = 1'b1;
		tick(4);
		chk("alt lines", 20'h5, {17'h0, alt});
		altEn = 1'b0;
		tick(1);
		chk("alt off", 20'h0, {17'h0, alt});
		for (int i = 0; i < 4; i++)
		begin
			{decEn, refSeen, locked} = rdy[i][3:1];
			tick(6);
			chk("ready", {19'h0, rdy[i][0]}, {19'h0, ready});
		end
		readReq = 1'b1;
		convEn = 1'b0;
		tick(6);
		chk("conv off", 20'h0, {coreRun, pioOe[18:0]});
		strapVal = 20'h0001F;
		convEn = 1'b1;
		tick(12);
		chk("straps again", 20'h3D, {14'h0, straps});
		porN = 1'b0;
		tick(6);
		chk("por", 20'h0, {14'h0, straps});
		chk("por oe", 20'h0, pioOe);
		results();
	end
endmodule

//--- src/dsp_defines.svh
// Constants for the decoder status parallel port
`ifndef DSP_DEFINES_SVH
`define DSP_DEFINES_SVH
`define DSP_CLK_PERIOD_PS 4000
`define DSP_STRAP_SETTLE_NS 100
`define DSP_STRAP_SETTLE_CYC ((`DSP_STRAP_SETTLE_NS * 1000 + `DSP_CLK_PERIOD_PS - 1) / `DSP_CLK_PERIOD_PS)
`define DSP_HDR_ID_EXT 11
`define DSP_HDR_ID 12
`define DSP_HDR_LAYER_HI 13
`define DSP_HDR_LAYER_LO 14
`define DSP_HDR_FS_HI 20
`define DSP_HDR_FS_LO 21
`define DSP_HDR_EMPH_HI 30
`define DSP_HDR_EMPH_LO 31
`define DSP_LAYER_2 2'h2
`define DSP_LAYER_3 2'h1
`define DSP_PIO_W 20
`define DSP_SYNC_STAGES 2
`define DSP_OUT_MASK 20'hE_311F
`define DSP_PIN_BCAST 0
`define DSP_PIN_WIDE 1
`define DSP_PIN_LAYER2 2
`define DSP_PIN_LAYER3 3
`define DSP_PIN_REFCLK 4
`define DSP_PIN_CLKDIV 8
`define DSP_PIN_ALT_DATA 14
`define DSP_PIN_ALT_FRAME 15
`define DSP_PIN_ALT_CLK 16
`define DSP_PIN_DEMAND 19
`endif

//--- src/dsp_hdr_mirror.sv
// Frame header mirror and error/sync status holder
`timescale 1ns/10ps
`include "dsp_defines.svh"
module dsp_hdr_mirror (
	// Clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// Decoder events
	input wire logic hdrValid,
	input wire logic [31:0] hdrWord,
	input wire logic frameFail,
	input wire logic frameStart,
	input wire logic ancRead,
	// Status
	output dsp_pkg::dsp_hdr_t hdr,
	output logic crcErr,
	output logic frameSync
);
	import dsp_pkg::*;

	dsp_hdr_t hdr_r;
	dsp_hdr_t hdr_nxt;
	logic crc_r;
	logic errPending_r;
	logic sync_r;
	wire logic layerOk;

	assign hdr_nxt = '{idExt: hdrWord[`DSP_HDR_ID_EXT],
		id: hdrWord[`DSP_HDR_ID],
		layerHi: hdrWord[`DSP_HDR_LAYER_HI],
		layerLo: hdrWord[`DSP_HDR_LAYER_LO],
		rateHi: hdrWord[`DSP_HDR_FS_HI],
		rateLo: hdrWord[`DSP_HDR_FS_LO],
		emphHi: hdrWord[`DSP_HDR_EMPH_HI],
		emphLo: hdrWord[`DSP_HDR_EMPH_LO]};
	assign layerOk = ({hdr_nxt.layerHi, hdr_nxt.layerLo} == `DSP_LAYER_2)
		|| ({hdr_nxt.layerHi, hdr_nxt.layerLo} == `DSP_LAYER_3);

	always_ff @(posedge core_clk)
	begin
		if (srst)
			hdr_r <= '0;
		else if (hdrValid)
			hdr_r <= hdr_nxt;
	end

	// A failure seen mid-frame is reported over the whole next frame
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			crc_r <= 1'b0;
			errPending_r <= 1'b0;
		end
		else if (frameStart)
		begin
			crc_r <= errPending_r | frameFail;
			errPending_r <= 1'b0;
		end
		else if (frameFail)
			errPending_r <= 1'b1;
	end

	// Header recognition wins over a same-cycle ancillary read
	always_ff @(posedge core_clk)
	begin
		if (srst)
			sync_r <= 1'b0;
		else if (hdrValid && layerOk)
			sync_r <= 1'b1;
		else if (ancRead)
			sync_r <= 1'b0;
	end

	assign hdr = hdr_r;
	assign crcErr = crc_r;
	assign frameSync = sync_r;

	hdr_hold_a: assert property (@(posedge core_clk) disable iff (srst)
		!$past(hdrValid) |-> $stable(hdr_r))
		else $error("header mirror changed without a header");
	sync_set_a: assert property (@(posedge core_clk) disable iff (srst)
		hdrValid && layerOk |=> sync_r)
		else $error("frame sync not set by valid header");
	crc_frame_a: assert property (@(posedge core_clk) disable iff (srst)
		crc_r && !frameStart |=> crc_r)
		else $error("crc error dropped inside a frame");
endmodule

//--- src/dsp_pkg.sv
// Types for the decoder status parallel port
package dsp_pkg;
	typedef struct packed {
		logic muteLayer3;
		logic muteLayer2;
		logic wideSamples;
		logic broadcastMode;
		logic clockDivOff;
		logic refClockAlt;
	} dsp_straps_t;

	typedef struct packed {
		logic idExt;
		logic id;
		logic layerHi;
		logic layerLo;
		logic rateHi;
		logic rateLo;
		logic emphHi;
		logic emphLo;
	} dsp_hdr_t;

	typedef enum logic [2:0] {
		DSP_RESET = 3'h1,
		DSP_STARTUP = 3'h2,
		DSP_OPERATE = 3'h4
	} dsp_state_t;
endpackage

//--- src/dsp_status_port.sv
// Decoder status parallel port with start-up straps
//
// Behaviour
// - Pins driven only when read qualifier high and chip select low.
// - Start-up samples the data pins as straps, ignoring handshake lines.
// - After start-up the port becomes status outputs.
// - Demand output high when new bit-stream data is wanted while the core runs.
// - ID, layer, rate, emphasis pins copy the latest frame header.
// - CRC error shown for one whole frame on any decode failure.
// - CRC pin read at start-up enables the clock output divider.
// - Frame sync low after reset, set by valid layer 2/3 header.
// - Frame sync cleared by an ancillary data read over I2C.
// - Frame sync pin at start-up selects reference clock frequency.
// - Rate and emphasis pins are inputs at start-up, outputs after.
// - Three port pins may act as alternate serial input lines.
// - With decoder disabled, ready shows a valid reference clock.
// - With decoder enabled, ready low until synthesizer locks.
// - Low power-on reset clears all digital logic except the pin synchronisers.
// - Converter enable low keeps processor and supervision idle.
// - DMA ready and end-of-DMA lines carry no function.
// - Header bits 20,21 and 30,31 shown on four status pins.
// - Two straps enable layer 3 and layer 2 decoding.
// - One strap selects 32-bit or 16-bit I2S output format.
// - One strap selects multimedia or broadcast mode.
`timescale 1ns/10ps
`include "dsp_defines.svh"
module dsp_status_port #(
	parameter int PIO_W = `DSP_PIO_W,
	parameter int SETTLE_CYC = `DSP_STRAP_SETTLE_CYC
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// Power and enables from pins
	input wire logic power_on_reset_n,
	input wire logic converter_enable_in,
	input wire logic decoder_enable_in,
	// Handshake pins
	input wire logic port_select_n,
	input wire logic port_read_qualifier,
	// Port data pins
	input wire logic [PIO_W-1:0] pioIn,
	output logic [PIO_W-1:0] pioOut,
	output logic [PIO_W-1:0] pioOe,
	// Decoder core side
	input wire logic refClockSeen,
	input wire logic synthLocked,
	input wire logic needData,
	input wire logic hdrValid,
	input wire logic [31:0] hdrWord,
	input wire logic frameFail,
	input wire logic frameStart,
	input wire logic ancRead,
	input wire logic altSerialEn,
	// Alternate serial input lines
	output logic alt_serial_in_clock,
	output logic alt_serial_in_frame,
	output logic alt_serial_in_data,
	// Status to the core
	output dsp_pkg::dsp_straps_t straps,
	output logic coreRun,
	output logic decoder_ready_out,
	output logic dma_ready_read,
	output logic dma_ready_write,
	output logic dma_end_flag
);
	import dsp_pkg::*;

	localparam int CW = $clog2(SETTLE_CYC + 1);

	dsp_state_t state_r;
	dsp_state_t state_nxt;
	logic [CW-1:0] cnt_r;
	dsp_straps_t straps_r;
	logic ready_r;
	logic [PIO_W-1:0] out_r;
	logic [PIO_W-1:0] oe_r;
	logic [PIO_W-1:0] pioSync;
	logic [2:0] ctlSync;
	logic [4:0] hsSync;
	dsp_hdr_t hdr;
	logic crcErr;
	logic frameSync;
	wire logic porN;
	wire logic convEn;
	wire logic decEn;
	wire logic selN;
	wire logic readQ;
	wire logic anyReset;
	wire logic settled;
	wire logic operate;
	wire logic portOn;
	wire logic [PIO_W-1:0] statusWord;
	wire logic [PIO_W-1:0] outMask;

	// Every pin input is synchronised before use
	dsp_sync #(.W(PIO_W)) u_pio_sync (
		.core_clk(core_clk),
		.srst(srst),
		.asyncIn(pioIn),
		.syncOut(pioSync)
	);
	dsp_sync #(.W(5)) u_hs_sync (
		.core_clk(core_clk),
		.srst(srst),
		.asyncIn({power_on_reset_n, converter_enable_in,
			decoder_enable_in, port_select_n, port_read_qualifier}),
		.syncOut(hsSync)
	);
	assign ctlSync = hsSync[4:2];
	assign porN = ctlSync[2];
	assign convEn = ctlSync[1];
	assign decEn = ctlSync[0];
	assign selN = hsSync[1];
	assign readQ = hsSync[0];

	// The synchroniser resets to zero, so the pin reset reads as held
	assign anyReset = srst || !porN;
	assign settled = (cnt_r == CW'(SETTLE_CYC));

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			DSP_RESET:
				if (convEn)
					state_nxt = DSP_STARTUP;
			DSP_STARTUP:
				if (!convEn)
					state_nxt = DSP_RESET;
				else if (settled)
					state_nxt = DSP_OPERATE;
			DSP_OPERATE:
				if (!convEn)
					state_nxt = DSP_RESET;
			default:
				state_nxt = DSP_RESET;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (anyReset)
			state_r <= DSP_RESET;
		else
			state_r <= state_nxt;
	end

	always_ff @(posedge core_clk)
	begin
		if (anyReset || state_r != DSP_STARTUP)
			cnt_r <= '0;
		else if (!settled)
			cnt_r <= cnt_r + CW'(1);
	end

	// Straps are caught only in the last start-up cycle, once the counter has settled
	// Re-enabling the converter runs start-up again and retakes them
	always_ff @(posedge core_clk)
	begin
		if (anyReset)
			straps_r <= '0;
		else if (state_r == DSP_STARTUP && settled)
		begin
			straps_r.muteLayer3 <= pioSync[`DSP_PIN_LAYER3];
			straps_r.muteLayer2 <= pioSync[`DSP_PIN_LAYER2];
			straps_r.wideSamples <= pioSync[`DSP_PIN_WIDE];
			straps_r.broadcastMode <= pioSync[`DSP_PIN_BCAST];
			straps_r.clockDivOff <= pioSync[`DSP_PIN_CLKDIV];
			straps_r.refClockAlt <= pioSync[`DSP_PIN_REFCLK];
		end
	end

	assign operate = (state_r == DSP_OPERATE);
	assign coreRun = operate && decEn;

	dsp_hdr_mirror u_hdr (
		.core_clk(core_clk),
		.srst(anyReset),
		.hdrValid(hdrValid && operate),
		.hdrWord(hdrWord),
		.frameFail(frameFail && operate),
		.frameStart(frameStart && operate),
		.ancRead(ancRead),
		.hdr(hdr),
		.crcErr(crcErr),
		.frameSync(frameSync)
	);

	assign statusWord = {needData && coreRun,
		hdr.idExt, hdr.id, 3'h0, hdr.layerHi, hdr.layerLo,
		3'h0, crcErr, 3'h0, frameSync,
		hdr.rateHi, hdr.rateLo, hdr.emphHi, hdr.emphLo};
	// Alternate serial inputs and pins 5..7, 9..11 are never driven
	assign outMask = `DSP_OUT_MASK;
	assign portOn = operate && !selN && readQ;

	// Enables follow the synchronised handshake, so the pins turn round
	// about three edges after select and read change

	always_ff @(posedge core_clk)
	begin
		if (anyReset)
		begin
			out_r <= '0;
			oe_r <= '0;
		end
		else
		begin
			out_r <= statusWord;
			oe_r <= portOn ? outMask : '0;
		end
	end

	assign pioOut = out_r;
	assign pioOe = oe_r;

	assign alt_serial_in_clock = altSerialEn
		&& pioSync[`DSP_PIN_ALT_CLK];
	assign alt_serial_in_frame = altSerialEn
		&& pioSync[`DSP_PIN_ALT_FRAME];
	assign alt_serial_in_data = altSerialEn
		&& pioSync[`DSP_PIN_ALT_DATA];

	always_ff @(posedge core_clk)
	begin
		if (anyReset)
			ready_r <= 1'b0;
		else if (!decEn)
			ready_r <= refClockSeen;
		else
			ready_r <= coreRun && synthLocked;
	end

	assign decoder_ready_out = ready_r;
	assign straps = straps_r;
	// No firmware support for the DMA lines
	assign dma_ready_read = 1'b0;
	assign dma_ready_write = 1'b0;
	assign dma_end_flag = 1'b0;

	sequence startupDone_s;
		state_r == DSP_STARTUP && settled && !anyReset;
	endsequence
	sequence operating_s;
		state_r == DSP_OPERATE;
	endsequence
	sequence hdrTaken_s;
		hdrValid && operate;
	endsequence

	oe_gate_a: assert property (@(posedge core_clk) disable iff (anyReset)
		(pioOe != '0) |-> $past(portOn))
		else $error("port driven without select and read");
	oe_startup_a: assert property (@(posedge core_clk) disable iff (anyReset)
		!operate |=> pioOe == '0)
		else $error("port driven during start-up");
	startup_exit_a: assert property (@(posedge core_clk)
		disable iff (anyReset || !convEn)
		startupDone_s |=> operating_s)
		else $error("start-up did not enter operation");
	strap_hold_a: assert property (@(posedge core_clk) disable iff (anyReset)
		operate |=> $stable(straps_r))
		else $error("straps changed in operation");
	strap_take_a: assert property (@(posedge core_clk) disable iff (anyReset)
		startupDone_s |=> straps_r.refClockAlt == $past(pioSync[4]))
		else $error("clock select strap not captured");
	ready_idle_a: assert property (@(posedge core_clk) disable iff (anyReset)
		!decEn |=> decoder_ready_out == $past(refClockSeen))
		else $error("ready does not show clock detect");
	ready_lock_a: assert property (@(posedge core_clk) disable iff (anyReset)
		decEn && !synthLocked |=> !decoder_ready_out)
		else $error("ready high before lock");
	conv_off_a: assert property (@(posedge core_clk) disable iff (srst)
		!porN || !convEn |=> !operate)
		else $error("operating with converter off or in reset");
	dma_idle_a: assert property (@(posedge core_clk)
		!(dma_ready_read || dma_ready_write || dma_end_flag))
		else $error("DMA line active");
	// Pin map and start-up counter checks
	demand_gate_a: assert property (
		@(posedge core_clk) disable iff (anyReset)
		pioOut[`DSP_PIN_DEMAND] |-> $past(needData) && $past(coreRun))
		else $error("demand shown while decoder idle");
	alt_gate_a: assert property (
		@(posedge core_clk)
		!altSerialEn |-> !(alt_serial_in_clock || alt_serial_in_frame
			|| alt_serial_in_data))
		else $error("alternate serial line active while off");
	alt_free_a: assert property (
		@(posedge core_clk) disable iff (anyReset)
		pioOe[`DSP_PIN_ALT_CLK:`DSP_PIN_ALT_DATA] == '0)
		else $error("alternate serial pin driven");
	hdr_pins_a: assert property (
		@(posedge core_clk) disable iff (anyReset)
		hdrTaken_s |=> ##1 pioOut[3:0] == {
			$past(hdrWord[`DSP_HDR_FS_HI], 2),
			$past(hdrWord[`DSP_HDR_FS_LO], 2),
			$past(hdrWord[`DSP_HDR_EMPH_HI], 2),
			$past(hdrWord[`DSP_HDR_EMPH_LO], 2)})
		else $error("rate or emphasis pins miss header");
	cnt_bound_a: assert property (
		@(posedge core_clk) disable iff (anyReset)
		cnt_r <= CW'(SETTLE_CYC))
		else $error("start-up counter overran");
endmodule

//--- src/dsp_sync.sv
// Two-stage synchroniser for a bus of pin inputs
`timescale 1ns/10ps
module dsp_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// Data
	input wire logic [W-1:0] asyncIn,
	output logic [W-1:0] syncOut
);
	logic [W-1:0] meta_r;
	logic [W-1:0] sync_r;

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			meta_r <= '0;
			sync_r <= '0;
		end
		else
		begin
			meta_r <= asyncIn;
			sync_r <= meta_r;
		end
	end

	assign syncOut = sync_r;
endmodule
